// File: pkg/two_wire_pkg.sv
// Summary of operation
// R1: only spi or two-wire port owns pins
// R2: select bit set gives pins to spi
// R3: own address register resets to 55h
// R4: data register access clears byte-done flag
// R5: data-out bit drives data pin when enabled
// R6: drive-enable bit makes data pin output
// R7: master mode clock pin follows clock-out bit
// R8: data-in bit latches pin on clock rise
// R9: mode bit selects master or slave
// R10: soft reset holds slave idle
// R11: direction bit takes received read/write bit
// R12: reset comes up slave, awaiting start
// R13: start, matching address sets byte-done flag
// R14: interrupt needs flag and both enables
// R15: interrupt vectors to 003bh
// R16: first byte shows address and read/write
// R17: second access per event stops slave
// R18: slave stretches clock while flag set
// R19: flag per acked byte, none on nack
// R20: stop or nack returns slave idle
// R21: one flag for address and data events
// R22: filter rejects pulses under 50 ns
// R23: software sequences master bus conditions
// R24: only matching address is acknowledged
`default_nettype none
package two_wire_pkg;
  // ==========================================
  // register offsets on the special-function bus
  localparam logic [7:0] ADDR_BUS_DATA = 8'h9a;
  localparam logic [7:0] ADDR_OWN_ADDRESS = 8'h9b;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;
  // reset values
  localparam logic [7:0] RST_BUS_DATA = 8'h00;
  localparam logic [7:0] RST_OWN_ADDRESS = 8'h55;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // control register field positions
  localparam int BIT_MDO = 7;
  localparam int BIT_MDE = 6;
  localparam int BIT_MCO = 5;
  localparam int BIT_MDI = 4;
  localparam int BIT_MASTER = 3;
  localparam int BIT_SRST = 2;
  localparam int BIT_DIR = 1;
  localparam int BIT_FLAG = 0;
  // interrupt vector of this port
  localparam logic [15:0] IRQ_VECTOR = 16'h003b;
  // glitch filter timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 50;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slave controller states
  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_hold, st_tx, st_tx_ack, st_stopped} slave_state_t;
endpackage : two_wire_pkg
`default_nettype wire

// File: rtl/two_wire_port.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_port import two_wire_pkg::*; #(
  parameter int FILTER_CYCLES = FILTER_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // select bit of the spi control register, high hands pins to spi
  input wire logic serial_port_select,
  input wire logic port_irq_enable,
  input wire logic global_irq_enable,
  output logic irq,
  output logic [15:0] irq_vector,
  // bus pins split into input, output and enable
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe
);

  // the filter counter is three bits wide, so refuse longer windows at elaboration
  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 7) begin : g_bad_filter
    $error("FILTER_CYCLES must lie in 1..7");
  end

  // ==========================================
  // pin synchronisers and glitch filter
  logic [1:0] meta_ff; // first stage, read only by sync_ff
  logic [1:0] sync_ff; // bit 1 clock, bit 0 data
  logic [1:0] filt_ff, nxt_filt;
  logic [1:0] prev_ff; // filtered level one cycle back
  logic [2:0] cnt_ff [2];
  logic [2:0] nxt_cnt [2];

  // a new level is accepted only after it held for the whole window
  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < 2; i++) begin
      nxt_cnt[i] = 3'h0;
      if (sync_ff[i] != filt_ff[i]) begin
        if (cnt_ff[i] == 3'(FILTER_CYCLES - 1)) begin
          nxt_filt[i] = sync_ff[i]; // R22
        end else begin
          nxt_cnt[i] = cnt_ff[i] + 3'h1;
        end
      end
    end
  end

  // idle bus is high, so the filter starts high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      filt_ff <= 2'h3;
      prev_ff <= 2'h3;
      cnt_ff[0] <= 3'h0;
      cnt_ff[1] <= 3'h0;
    end else begin
      meta_ff <= {serial_clock_pin_in, serial_data_pin_in};
      sync_ff <= meta_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
      cnt_ff[0] <= nxt_cnt[0];
      cnt_ff[1] <= nxt_cnt[1];
    end
  end

  // bus events from the filtered levels
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = filt_ff[1] & ~prev_ff[1];
  assign scl_fall = ~filt_ff[1] & prev_ff[1];
  assign bus_start = filt_ff[1] & prev_ff[1] & prev_ff[0] & ~filt_ff[0];
  assign bus_stop = filt_ff[1] & prev_ff[1] & ~prev_ff[0] & filt_ff[0];

  // ==========================================
  // registers and slave controller
  slave_state_t state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift; // serial shift register
  logic [3:0] bits_ff, nxt_bits; // bits done in current byte
  logic addr_phase_ff, nxt_addr_phase; // next byte is the address
  logic [7:0] data_ff, nxt_data; // bus data register
  logic [7:0] own_addr_ff, nxt_own_addr; // own bus address register
  logic mdo_ff, nxt_mdo, mde_ff, nxt_mde, mco_ff, nxt_mco, mdi_ff, nxt_mdi;
  logic master_ff, nxt_master, srst_ff, nxt_srst, dir_ff, nxt_dir;
  logic flag_ff, nxt_flag; // byte-done flag
  logic accessed_ff, nxt_accessed; // data register touched since last event
  logic [7:0] rdata_ff, nxt_rdata;
  logic data_acc, ctrl_wr, slave_on, flag_set;

  assign data_acc = (sfr_rd | sfr_wr) && sfr_addr == ADDR_BUS_DATA;
  assign ctrl_wr = sfr_wr && sfr_addr == ADDR_CONTROL;
  // slave runs only when it owns the pins, is not master and not in reset
  assign slave_on = ~serial_port_select & ~master_ff & ~srst_ff; // R2 R9 R10

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_addr_phase = addr_phase_ff;
    nxt_data = data_ff;
    nxt_own_addr = own_addr_ff;
    nxt_mdo = mdo_ff;
    nxt_mde = mde_ff;
    nxt_mco = mco_ff;
    nxt_mdi = mdi_ff;
    nxt_master = master_ff;
    nxt_srst = srst_ff;
    nxt_dir = dir_ff;
    nxt_flag = flag_ff;
    nxt_accessed = accessed_ff;
    nxt_rdata = 8'h00;
    flag_set = 1'b0;
    // register reads, unmapped offsets read zero
    if (sfr_rd) begin
      if (sfr_addr == ADDR_BUS_DATA) begin
        nxt_rdata = data_ff;
      end else if (sfr_addr == ADDR_OWN_ADDRESS) begin
        nxt_rdata = own_addr_ff;
      end else if (sfr_addr == ADDR_CONTROL) begin
        nxt_rdata = {mdo_ff, mde_ff, mco_ff, mdi_ff, master_ff, srst_ff, dir_ff, flag_ff};
      end
    end
    // register writes; data-in and direction are read only
    if (sfr_wr && sfr_addr == ADDR_BUS_DATA) nxt_data = sfr_wdata;
    if (sfr_wr && sfr_addr == ADDR_OWN_ADDRESS) nxt_own_addr = sfr_wdata; // R3
    if (ctrl_wr) begin
      nxt_mdo = sfr_wdata[BIT_MDO];
      nxt_mde = sfr_wdata[BIT_MDE];
      nxt_mco = sfr_wdata[BIT_MCO];
      nxt_master = sfr_wdata[BIT_MASTER]; // R9
      nxt_srst = sfr_wdata[BIT_SRST]; // R10
      if (!sfr_wdata[BIT_FLAG]) nxt_flag = 1'b0;
    end
    // any data register access clears the flag
    if (data_acc) begin
      nxt_flag = 1'b0; // R4
      nxt_accessed = 1'b1;
    end
    // master data-in samples the pin on clock rise while not driving
    if (master_ff && !mde_ff && scl_rise) nxt_mdi = filt_ff[0]; // R8
    // slave controller
    if (!slave_on) begin
      nxt_state = st_idle; // R10
      nxt_bits = 4'h0;
      if (srst_ff) nxt_flag = 1'b0;
    end else if (state_ff == st_stopped) begin
      nxt_state = st_stopped; // R17
    end else if (data_acc && accessed_ff) begin
      nxt_state = st_stopped; // R17
    end else if (bus_start) begin
      nxt_state = st_rx;
      nxt_addr_phase = 1'b1;
      nxt_bits = 4'h0;
    end else if (bus_stop) begin
      nxt_state = st_idle; // R20
    end else begin
      case (state_ff)
        st_rx: begin
          if (scl_rise && bits_ff < 4'h8) begin
            nxt_shift = {shift_ff[6:0], filt_ff[0]};
            nxt_bits = bits_ff + 4'h1;
          end else if (scl_fall && bits_ff == 4'h8) begin
            nxt_bits = 4'h0;
            if (!addr_phase_ff) begin
              nxt_state = st_ack;
            end else if (shift_ff[7:1] == own_addr_ff[6:0]) begin
              nxt_state = st_ack; // R24
              nxt_dir = shift_ff[0]; // R11
            end else begin
              nxt_state = st_idle; // R24
            end
          end
        end
        // end of ack clock: publish byte, raise flag, stretch
        st_ack: begin
          if (scl_fall) begin
            nxt_data = shift_ff; // R16
            flag_set = 1'b1; // R13 R19 R21
            nxt_state = st_hold;
          end
        end
        // wait for software, then go on in the chosen direction
        st_hold: begin
          if (!flag_ff) begin
            nxt_addr_phase = 1'b0;
            nxt_bits = 4'h0;
            if (dir_ff) begin
              nxt_shift = data_ff;
              nxt_state = st_tx;
            end else begin
              nxt_state = st_rx;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b1};
            nxt_bits = bits_ff + 4'h1;
            if (bits_ff == 4'h7) nxt_state = st_tx_ack;
          end
        end
        // master answers; a nack ends the sequence without a flag
        st_tx_ack: begin
          if (scl_rise) begin
            nxt_shift[0] = filt_ff[0];
          end else if (scl_fall) begin
            if (shift_ff[0]) begin
              nxt_state = st_idle; // R19 R20
            end else begin
              flag_set = 1'b1; // R19
              nxt_state = st_hold;
            end
          end
        end
        default: nxt_state = st_idle;
      endcase
    end
    // a new event outranks a clear in the same cycle
    if (flag_set) begin
      nxt_flag = 1'b1;
      nxt_accessed = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= st_idle; // R12
      shift_ff <= 8'h00;
      bits_ff <= 4'h0;
      addr_phase_ff <= 1'b1;
      data_ff <= RST_BUS_DATA;
      own_addr_ff <= RST_OWN_ADDRESS; // R3
      {mdo_ff, mde_ff, mco_ff, mdi_ff, master_ff, srst_ff, dir_ff, flag_ff} <= RST_CONTROL; // R12
      accessed_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      addr_phase_ff <= nxt_addr_phase;
      data_ff <= nxt_data;
      own_addr_ff <= nxt_own_addr;
      mdo_ff <= nxt_mdo;
      mde_ff <= nxt_mde;
      mco_ff <= nxt_mco;
      mdi_ff <= nxt_mdi;
      master_ff <= nxt_master;
      srst_ff <= nxt_srst;
      dir_ff <= nxt_dir;
      flag_ff <= nxt_flag;
      accessed_ff <= nxt_accessed;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================
  // outputs
  assign sfr_rdata = rdata_ff;
  assign irq = flag_ff & port_irq_enable & global_irq_enable; // R14
  assign irq_vector = IRQ_VECTOR; // R15

  // pins go quiet while the spi port owns them
  always_comb begin
    serial_data_pin_out = 1'b0;
    serial_data_pin_oe = 1'b0;
    serial_clock_pin_out = 1'b0;
    serial_clock_pin_oe = 1'b0;
    if (serial_port_select) begin
      serial_data_pin_oe = 1'b0; // R1
    end else if (master_ff) begin
      serial_data_pin_out = mdo_ff; // R5
      serial_data_pin_oe = mde_ff; // R6
      serial_clock_pin_out = mco_ff; // R7
      serial_clock_pin_oe = 1'b1; // R7
    end else begin
      // open-drain: only ever pull low
      serial_data_pin_oe = state_ff == st_ack || (state_ff == st_tx && !shift_ff[7]); // R24
      serial_clock_pin_oe = state_ff == st_hold && flag_ff; // R18
    end
  end

  // ==========================================
  // checks
  sequence s_addr_match;
    state_ff == st_rx && addr_phase_ff && scl_fall && bits_ff == 4'h8 && shift_ff[7:1] == own_addr_ff[6:0];
  endsequence
  sequence s_ack_end;
    state_ff == st_ack && scl_fall && slave_on && !bus_start && !bus_stop && !(data_acc && accessed_ff);
  endsequence

  a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
    irq == (flag_ff && port_irq_enable && global_irq_enable)) else $error("irq gating wrong"); // R14
  a_data_clear: assert property (@(posedge core_clk) disable iff (rst)
    data_acc && !flag_set |=> !flag_ff) else $error("data access did not clear flag"); // R4
  a_ack_flag: assert property (@(posedge core_clk) disable iff (rst)
    s_ack_end |=> flag_ff && data_ff == $past(shift_ff) && state_ff == st_hold) else $error("ack end no flag"); // R13
  a_addr_dir: assert property (@(posedge core_clk) disable iff (rst)
    s_addr_match and (slave_on && !bus_start && !bus_stop && !(data_acc && accessed_ff) ##0 1)
    |=> dir_ff == $past(shift_ff[0]) && state_ff == st_ack) else $error("direction not taken"); // R11
  a_stretch: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == st_hold && flag_ff && !master_ff && !serial_port_select |-> serial_clock_pin_oe && !serial_clock_pin_out)
    else $error("clock not stretched"); // R18
  a_master_pins: assert property (@(posedge core_clk) disable iff (rst)
    master_ff && !serial_port_select |-> serial_clock_pin_oe && serial_clock_pin_out == mco_ff
    && serial_data_pin_oe == mde_ff) else $error("master pins wrong"); // R7
  a_soft_reset: assert property (@(posedge core_clk) disable iff (rst)
    srst_ff |=> state_ff == st_idle && !flag_ff) else $error("soft reset not idle"); // R10
  a_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
    slave_on && bus_stop && !bus_start && state_ff != st_stopped && !(data_acc && accessed_ff)
    |=> state_ff == st_idle) else $error("stop not idle"); // R20
  a_double_stop: assert property (@(posedge core_clk) disable iff (rst)
    slave_on && data_acc && accessed_ff ##1 slave_on |-> state_ff == st_stopped) else $error("double access"); // R17
  a_spi_owns: assert property (@(posedge core_clk) disable iff (rst)
    serial_port_select |-> !serial_data_pin_oe && !serial_clock_pin_oe) else $error("pins driven under spi"); // R1
  a_filter_glitch: assert property (@(posedge core_clk) disable iff (rst)
    $changed(filt_ff[0]) |-> $past(sync_ff[0], 1) == filt_ff[0]) else $error("filter took glitch"); // R22

endmodule : two_wire_port
`default_nettype wire

// File: testbench/bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// external open-drain bus master, lines float high when released
module bus_master_model #(
  parameter int HALF = 16
) (
  input wire logic core_clk,
  input wire logic sda_lvl,
  input wire logic scl_lvl,
  output logic sda_low,
  output logic scl_low,
  output logic stall_err
);
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    stall_err = 1'b0;
  end
  // idle for a number of core clocks; steps on falling edges so the lines move away from sampling
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask : gap
  // release clock, then honour stretching with a bound
  task automatic rise;
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_lvl !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) stall_err = 1'b1;
  endtask : rise
  // data moves only well after the fall, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    gap(HALF);
    sda_low = ~b;
    gap(HALF);
    rise;
    gap(HALF);
    s = sda_lvl;
    gap(HALF);
    scl_low = 1'b1;
  endtask : bit_io
  task automatic start_c;
    sda_low = 1'b0;
    gap(HALF);
    rise;
    gap(HALF);
    sda_low = 1'b1;
    gap(HALF);
    scl_low = 1'b1;
  endtask : start_c
  task automatic stop_c;
    gap(HALF);
    sda_low = 1'b1;
    gap(HALF);
    rise;
    gap(HALF);
    sda_low = 1'b0;
    gap(HALF);
  endtask : stop_c
  // msb first, then sample the ack clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask : get_byte
endmodule : bus_master_model
`default_nettype wire

// File: testbench/two_wire_slave_and_bitbang_master_tb.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_and_bitbang_master_tb import two_wire_pkg::*; ;
  // ==========================================
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic spi_sel = 1'b0;
  logic [1:0] irq_en = 2'b00;
  logic tb_sda_low = 1'b0; // bench pulls data low in master tests
  logic tb_scl_low = 1'b0; // bench glitches the clock line
  logic [7:0] sfr_rdata;
  logic [15:0] irq_vector;
  logic irq, d_out, d_oe, c_out, c_oe, sda_low, scl_low, stall_err;
  logic [7:0] rd, adr, dat;
  logic ack;
  int miscompares = 0;
  int comparisons = 0;
  // wired-and with pull-ups; master mode may drive high
  wire sda_lvl = ~sda_low & ~tb_sda_low & ~(d_oe & ~d_out);
  wire scl_lvl = ~scl_low & ~tb_scl_low & ~(c_oe & ~c_out);
  always #5 core_clk = ~core_clk;
  two_wire_port #(.FILTER_CYCLES(FILTER_CYC)) dut_u (.core_clk(core_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .serial_port_select(spi_sel), .port_irq_enable(irq_en[0]), .global_irq_enable(irq_en[1]),
    .irq(irq), .irq_vector(irq_vector), .serial_data_pin_in(sda_lvl), .serial_data_pin_out(d_out),
    .serial_data_pin_oe(d_oe), .serial_clock_pin_in(scl_lvl), .serial_clock_pin_out(c_out),
    .serial_clock_pin_oe(c_oe));
  bus_master_model #(.HALF(16)) master_u (.core_clk(core_clk), .sda_lvl(sda_lvl), .scl_lvl(scl_lvl),
    .sda_low(sda_low), .scl_low(scl_low), .stall_err(stall_err));
  // ==========================================
  // shared tasks
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : reg_wr
  // read data is registered on the taking edge and sampled at the next falling edge
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    rd = sfr_rdata;
    sfr_rd = 1'b0;
    check(n, rd & m, e);
  endtask : chk_rd
  // bounded wait for the slave to stretch the clock
  task automatic wait_hold;
    int n;
    n = 0;
    while (c_oe !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    check("stretch", c_oe, 1'b1);
    if (c_oe !== 1'b1) end_of_test;
  endtask : wait_hold
  task automatic addr_phase(input logic rw, input logic exp_ack);
    master_u.start_c;
    master_u.put_byte({adr[6:0], rw}, ack);
    check("addr ack", ack, exp_ack);
  endtask : addr_phase
  always @(posedge stall_err) begin
    miscompares++;
    end_of_test;
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'hdc93));
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    check("vector", irq_vector, IRQ_VECTOR);
    check("pins idle", {irq, d_oe, c_oe}, 3'b000);
    chk_rd(ADDR_OWN_ADDRESS, 8'hff, RST_OWN_ADDRESS, "address");
    chk_rd(ADDR_CONTROL, 8'hff, RST_CONTROL, "control");
    chk_rd(ADDR_BUS_DATA, 8'hff, RST_BUS_DATA, "data");
    reg_wr(8'h9c, 8'hff);
    chk_rd(8'h9c, 8'hff, 8'h00, "unmapped");
    $display("test reset done");
    // slave receive: address then one data byte
    adr = {1'b0, 7'($urandom)};
    reg_wr(ADDR_OWN_ADDRESS, adr);
    chk_rd(ADDR_OWN_ADDRESS, 8'h7f, adr, "address wr");
    addr_phase(1'b0, 1'b1);
    wait_hold;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      irq_en = 2'(i);
      @(negedge core_clk);
      check("irq", irq, i == 3);
    end
    chk_rd(ADDR_CONTROL, 8'h03, 8'h01, "flag dir");
    chk_rd(ADDR_BUS_DATA, 8'hff, {adr[6:0], 1'b0}, "addr byte");
    check("irq clr", irq, 1'b0);
    dat = 8'($urandom);
    master_u.put_byte(dat, ack);
    check("data ack", ack, 1'b1);
    wait_hold;
    chk_rd(ADDR_BUS_DATA, 8'hff, dat, "rx byte");
    master_u.stop_c;
    $display("test receive done");
    // a foreign address is ignored
    adr = adr ^ 8'h01;
    addr_phase(1'b0, 1'b0);
    adr = adr ^ 8'h01;
    master_u.stop_c;
    chk_rd(ADDR_CONTROL, 8'h01, 8'h00, "no flag");
    $display("test mismatch done");
    // slave transmit, master ends with nack
    addr_phase(1'b1, 1'b1);
    wait_hold;
    chk_rd(ADDR_CONTROL, 8'h03, 8'h03, "dir tx");
    dat = 8'($urandom);
    reg_wr(ADDR_BUS_DATA, dat);
    check("irq wr clr", irq, 1'b0);
    master_u.get_byte(1'b1, rd);
    check("tx byte", rd, dat);
    repeat (20) @(negedge core_clk);
    chk_rd(ADDR_CONTROL, 8'h01, 8'h00, "nack flag");
    master_u.stop_c;
    $display("test transmit done");
    // double access stops the slave until soft reset
    addr_phase(1'b0, 1'b1);
    wait_hold;
    chk_rd(ADDR_BUS_DATA, 8'hff, {adr[6:0], 1'b0}, "first");
    chk_rd(ADDR_BUS_DATA, 8'hff, {adr[6:0], 1'b0}, "second");
    master_u.stop_c;
    addr_phase(1'b0, 1'b0);
    master_u.stop_c;
    reg_wr(ADDR_CONTROL, 8'h04);
    reg_wr(ADDR_CONTROL, 8'h00);
    addr_phase(1'b0, 1'b1);
    wait_hold;
    chk_rd(ADDR_BUS_DATA, 8'hff, {adr[6:0], 1'b0}, "after srst");
    master_u.stop_c;
    $display("test stop and soft reset done");
    // software master: every combination of the pin bits
    for (int i = 0; i < 8; i++) begin
      reg_wr(ADDR_CONTROL, {3'(i), 5'h08});
      @(negedge core_clk);
      check("pins", {d_oe, d_out & d_oe, c_oe, c_out}, {i[1], i[2] & i[1], 1'b1, i[0]});
    end
    for (int i = 0; i < 2; i++) begin
      tb_sda_low = i[0];
      reg_wr(ADDR_CONTROL, 8'h08);
      // clock must stay low longer than the filter window, or the rise is lost
      repeat (10) @(negedge core_clk);
      reg_wr(ADDR_CONTROL, 8'h28);
      repeat (10) @(negedge core_clk);
      tb_sda_low = ~i[0];
      repeat (10) @(negedge core_clk);
      chk_rd(ADDR_CONTROL, 8'h10, {3'b000, ~i[0], 4'h0}, "data in");
    end
    // a 40 ns clock dip must not look like a rising edge
    tb_scl_low = 1'b1;
    repeat (4) @(negedge core_clk);
    tb_scl_low = 1'b0;
    repeat (10) @(negedge core_clk);
    chk_rd(ADDR_CONTROL, 8'h10, 8'h00, "glitch");
    spi_sel = 1'b1;
    @(negedge core_clk);
    check("spi owns", {d_oe, c_oe}, 2'b00);
    spi_sel = 1'b0;
    @(negedge core_clk);
    check("port owns", c_oe, 1'b1);
    reg_wr(ADDR_CONTROL, 8'h00);
    $display("test master done");
    end_of_test;
  end
endmodule : two_wire_slave_and_bitbang_master_tb
`default_nettype wire
